// ### dmahs_top.v
`timescale 1ns/10ps
module dmahs_top (
   // clock and reset
   input  wire        CLK_SYS,
   input  wire        RST_B,
   // configuration
   input  wire [1:0]  MODE,
   input  wire        DIR_WRITE,
   input  wire [2:0]  WAIT_STATES,
   input  wire        IDLE_EN,
   input  wire [23:0] START_ADDR,
   input  wire [3:0]  MEM_SEL,
   // external pins
   input  wire        DMA_REQ_N,
   output reg         DMA_GRANT_N,
   output reg  [23:0] EXT_ADDR_BUS,
   output reg         RD_N,
   output reg         WR_N,
   output reg  [3:0]  MEM_SELECT_N,
   input  wire        ACK,
   input  wire [31:0] DATA_IN,
   output reg  [31:0] DATA_OUT,
   output reg         DATA_OE,
   // internal write source (to external party)
   input  wire        TX_VALID,
   output reg         TX_READY,
   input  wire [31:0] TX_DATA,
   // internal read sink (from external party)
   output reg         RX_VALID,
   input  wire        RX_READY,
   output reg  [31:0] RX_DATA,
   // status
   output reg         BUSY,
   output reg  [15:0] XFER_COUNT
);
`include "dmahs_defines.vh"
   // =======================================
   // states
   localparam ST_IDLE  = 3'h0;
   localparam ST_GAP   = 3'h1;
   localparam ST_WAIT  = 3'h2;
   localparam ST_ACT   = 3'h3;
   localparam ST_HOLD  = 3'h4;
   localparam ST_END   = 3'h5;

   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg  [2:0]  wcnt_ff;
   reg  [2:0]  nxt_wcnt;
   reg  [1:0]  div_ff;
   reg         idle_pend_ff;
   reg  [23:0] addr_ff;
   reg         req_q_ff;
   wire        req_sync_n;
   wire        bus_en;
   wire        req_fall;
   wire        rx_in_ready;
   wire        rx_out_valid;
   wire [31:0] rx_out_data;
   wire        use_grant;
   wire        ready_bus;
   wire        room_ok;
   wire        ack_sync;
   wire        rx_push;
   wire        rx_take;

   function [23:0] addr_next;
      input [23:0] a;
      begin
         addr_next = a + `DMAHS_ADDR_STEP;
      end
   endfunction

   // =======================================
   // request synchroniser and bus-period enable
   dmahs_sync2 u_req_sync (
      .clk   (CLK_SYS),
      .rst_b (RST_B),
      .d     (DMA_REQ_N),
      .q     (req_sync_n)
   );

   // acknowledge is a pin as well
   dmahs_sync2 u_ack_sync (
      .clk   (CLK_SYS),
      .rst_b (RST_B),
      .d     (ACK),
      .q     (ack_sync)
   );

   assign bus_en    = (div_ff == `DMAHS_BUS_DIV);
   // falling edge seen at a bus edge; later ones wait for the next edge
   assign req_fall  = bus_en & ~req_sync_n & req_q_ff;
   assign use_grant = (MODE != `DMAHS_MODE_PACED);
   assign ready_bus = (MODE == `DMAHS_MODE_HS) | ack_sync;
   assign room_ok   = DIR_WRITE ? TX_VALID : rx_in_ready;
   // read word taken on the edge that ends the strobe, while still driven
   assign rx_push   = bus_en & (state_ff == ST_HOLD) & (nxt_state == ST_END) & ~DIR_WRITE;
   // output stage reloads only once the sink has taken its word
   assign rx_take   = ~RX_VALID | RX_READY;

   // =======================================
   // read data buffer
   dmahs_buf2 u_rx_buf (
      .clk       (CLK_SYS),
      .rst_b     (RST_B),
      .in_valid  (rx_push),
      .in_ready  (rx_in_ready),
      .in_data   (DATA_IN),
      .out_valid (rx_out_valid),
      .out_ready (rx_take),
      .out_data  (rx_out_data)
   );

   // =======================================
   // next state
   always @* begin
      nxt_state = state_ff;
      nxt_wcnt  = wcnt_ff;
      if (bus_en) begin
         case (state_ff)
            ST_IDLE: begin
               if (req_fall & room_ok) begin
                  if (idle_pend_ff) begin
                     nxt_state = ST_GAP;
                  end else begin
                     nxt_state = ST_ACT;
                     nxt_wcnt  = WAIT_STATES;
                  end
               end
            end
            ST_GAP: begin
               nxt_state = ST_ACT;
               nxt_wcnt  = WAIT_STATES;
            end
            ST_ACT: begin
               if (wcnt_ff != `DMAHS_ZERO_W) begin
                  nxt_state = ST_WAIT;
                  nxt_wcnt  = wcnt_ff - `DMAHS_ONE_W;
               end else begin
                  nxt_state = ST_HOLD;
               end
            end
            ST_WAIT: begin
               if (wcnt_ff != `DMAHS_ZERO_W)
                  nxt_wcnt = wcnt_ff - `DMAHS_ONE_W;
               else
                  nxt_state = ST_HOLD;
            end
            ST_HOLD: begin
               // held request stretches by whole bus periods
               if (req_sync_n & ready_bus)
                  nxt_state = ST_END;
            end
            ST_END: begin
               nxt_state = ST_IDLE;
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   // =======================================
   // sequencer and pins
   always @(posedge CLK_SYS) begin
      if (!RST_B) begin
         state_ff     <= ST_IDLE;
         wcnt_ff      <= `DMAHS_ZERO_W;
         div_ff       <= 2'h0;
         idle_pend_ff <= 1'b0;
         addr_ff      <= 24'h000000;
         req_q_ff     <= 1'b1;
         DMA_GRANT_N  <= 1'b1;
         EXT_ADDR_BUS <= 24'h000000;
         RD_N         <= 1'b1;
         WR_N         <= 1'b1;
         MEM_SELECT_N <= `DMAHS_MS_NONE;
         DATA_OUT     <= 32'h00000000;
         DATA_OE      <= 1'b0;
         TX_READY     <= 1'b0;
         RX_VALID     <= 1'b0;
         RX_DATA      <= 32'h00000000;
         BUSY         <= 1'b0;
         XFER_COUNT   <= 16'h0000;
      end else begin
         div_ff   <= bus_en ? 2'h0 : div_ff + 2'h1;
         state_ff <= nxt_state;
         wcnt_ff  <= nxt_wcnt;
         TX_READY <= 1'b0;
         if (rx_take) begin
            RX_VALID <= rx_out_valid;
            RX_DATA  <= rx_out_data;
         end
         BUSY     <= (nxt_state != ST_IDLE);
         if (bus_en)
            req_q_ff <= req_sync_n;
         if (MODE == `DMAHS_MODE_HS)
            addr_ff <= START_ADDR;
         if (bus_en) begin
            case (nxt_state)
               ST_ACT, ST_WAIT, ST_HOLD: begin
                  // strobe asserted; grant asserted with it except in paced mode
                  DMA_GRANT_N <= ~use_grant;
                  RD_N        <= DIR_WRITE;
                  WR_N        <= ~DIR_WRITE;
                  if (MODE != `DMAHS_MODE_HS) begin
                     EXT_ADDR_BUS <= addr_ff;
                     MEM_SELECT_N <= ~MEM_SEL;
                  end
                  DATA_OE  <= DIR_WRITE;
                  if (DIR_WRITE & (nxt_state == ST_ACT)) begin
                     DATA_OUT <= TX_DATA;
                  end
               end
               default: begin
                  // grant and strobes end on the same edge
                  DMA_GRANT_N  <= 1'b1;
                  RD_N         <= 1'b1;
                  WR_N         <= 1'b1;
                  MEM_SELECT_N <= `DMAHS_MS_NONE;
                  DATA_OE      <= 1'b0;
               end
            endcase
            if (state_ff == ST_HOLD && nxt_state == ST_END) begin
               idle_pend_ff <= IDLE_EN;
               XFER_COUNT   <= XFER_COUNT + 16'h0001;
               if (MODE != `DMAHS_MODE_HS)
                  addr_ff <= addr_next(addr_ff);
               if (DIR_WRITE)
                  TX_READY <= 1'b1;
            end
            if (state_ff == ST_GAP)
               idle_pend_ff <= 1'b0;
            if (state_ff == ST_IDLE && nxt_state == ST_ACT)
               idle_pend_ff <= 1'b0;
         end
      end
   end
endmodule // dmahs_top

// ### dmahs_defines.vh
`ifndef DMAHS_DEFINES_VH
`define DMAHS_DEFINES_VH
// ==========================================
// widths
`define DMAHS_AW          24
`define DMAHS_DW          32
`define DMAHS_WW          3
`define DMAHS_MSW         4
// ==========================================
// handshake modes
`define DMAHS_MODE_HS     2'h0
`define DMAHS_MODE_EXT    2'h1
`define DMAHS_MODE_PACED  2'h2
// ==========================================
// fixed counts
`define DMAHS_ONE_W       3'h1
`define DMAHS_ZERO_W      3'h0
`define DMAHS_ADDR_STEP   24'h000001
`define DMAHS_MS_NONE     4'hf
// ==========================================
// bus period divider (bus clock = CLK_SYS / 2)
`define DMAHS_BUS_DIV     2'h1
`endif

// ### dmahs_buf2.v
`timescale 1ns/10ps
// two-entry buffer: a stall on the drain side loses no word
module dmahs_buf2 (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        in_valid,
   output wire        in_ready,
   input  wire [31:0] in_data,
   output wire        out_valid,
   input  wire        out_ready,
   output wire [31:0] out_data
);
`include "dmahs_defines.vh"
   reg  [31:0] mem_ff [0:1];
   reg         wp_ff;
   reg         rp_ff;
   reg  [1:0]  cnt_ff;
   wire        push;
   wire        pop;
   assign in_ready  = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data  = mem_ff[rp_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always @(posedge clk) begin
      if (!rst_b) begin
         wp_ff  <= 1'b0;
         rp_ff  <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         if (push) begin
            mem_ff[wp_ff] <= in_data;
            wp_ff         <= ~wp_ff;
         end
         if (pop)
            rp_ff <= ~rp_ff;
         if (push & ~pop)
            cnt_ff <= cnt_ff + 2'h1;
         else if (pop & ~push)
            cnt_ff <= cnt_ff - 2'h1;
      end
   end
endmodule // dmahs_buf2

// ### dmahs_sync2.v
`timescale 1ns/10ps
// two-flop synchroniser for a pin level
module dmahs_sync2 (
   input  wire clk,
   input  wire rst_b,
   input  wire d,
   output wire q
);
   reg meta_ff;
   reg q_ff;
   assign q = q_ff;
   always @(posedge clk) begin
      if (!rst_b) begin
         meta_ff <= 1'b1;
         q_ff    <= 1'b1;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end
endmodule // dmahs_sync2

// ### dmahs_props.sv
`timescale 1ns/10ps
`include "dmahs_defines.vh"
// ==========================================
// checker on the pins of the handshake port
module dmahs_props (
   // clock and reset
   input wire        CLK_SYS,
   input wire        RST_B,
   // configuration and pins
   input wire [1:0]  MODE,
   input wire [2:0]  WAIT_STATES,
   input wire        DMA_REQ_N,
   input wire        DMA_GRANT_N,
   input wire        RD_N,
   input wire        WR_N,
   input wire [15:0] XFER_COUNT
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   reg [5:0] low_ff = 6'h0;
   always @(posedge CLK_SYS) low_ff <= DMA_GRANT_N ? 6'h0 : low_ff + 6'h1;
   chk_paced_no_grant: assert property (MODE == `DMAHS_MODE_PACED |-> DMA_GRANT_N)
      else $error("grant in paced mode");
   chk_req_starts: assert property ($fell(RD_N & WR_N) |-> !$past(DMA_REQ_N, 2))
      else $error("strobe without request");
   chk_strobe_start: assert property ($fell(DMA_GRANT_N) |-> !(RD_N & WR_N))
      else $error("grant without strobe");
   chk_strobe_end: assert property ($rose(DMA_GRANT_N) |-> RD_N && WR_N)
      else $error("strobe outlives grant");
   // low_ff lags the pin by one sample at the rising edge
   chk_wait_width: assert property ($rose(DMA_GRANT_N) |->
      low_ff >= {2'h0, WAIT_STATES, 1'h0} + 6'h3) else $error("grant too short");
   chk_grant_rest: assert property ($rose(DMA_GRANT_N) |=> DMA_GRANT_N)
      else $error("grant not idle between transfers");
   chk_hold_off: assert property (!DMA_GRANT_N && !DMA_REQ_N |=> !DMA_GRANT_N)
      else $error("grant ended under held request");
   chk_count_step: assert property ($changed(XFER_COUNT) |->
      XFER_COUNT == $past(XFER_COUNT) + 16'h1) else $error("count jumped");
   cover property ($fell(DMA_GRANT_N));
   cover property (MODE == `DMAHS_MODE_PACED && $fell(RD_N));
   cover property ((!DMA_GRANT_N && !DMA_REQ_N) [*3]);
endmodule // dmahs_props
bind dmahs_top dmahs_props chk_u (.CLK_SYS, .RST_B, .MODE, .WAIT_STATES, .DMA_REQ_N,
   .DMA_GRANT_N, .RD_N, .WR_N, .XFER_COUNT);

// ### dmahs_party.sv
`timescale 1ns/10ps
// ==========================================
// requesting peripheral: holds request until served plus hold cycles
module dmahs_party (
   // bench control
   input  wire        clk,
   input  wire        rst_b,
   input  wire        go,
   input  wire [3:0]  hold,
   input  wire [31:0] word,
   // device pins
   input  wire        grant_n,
   input  wire        rd_n,
   input  wire        wr_n,
   output reg         req_n,
   output wire        ack,
   output wire [31:0] data_in
);
   reg [3:0] cnt_ff = 4'h0;
   reg [3:0] acnt_ff = 4'h0;
   // inverted outside the read so stale data cannot match
   assign data_in = rd_n ? ~word : word;
   // acknowledge withheld for the first six cycles of every access
   assign ack     = (acnt_ff >= 4'h6);
   always @(posedge clk) begin
      if (!rst_b || (grant_n & rd_n & wr_n))
         acnt_ff <= 4'h0;
      else if (acnt_ff != 4'hf)
         acnt_ff <= acnt_ff + 4'h1;
   end
   always @(posedge clk) begin
      if (!rst_b || go) begin
         req_n  <= ~go;
         cnt_ff <= 4'h0;
      end else if (!req_n && !(grant_n & rd_n & wr_n)) begin
         if (cnt_ff == hold) req_n <= 1'b1;
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule // dmahs_party

// ### dmahs_top_tb.sv
`timescale 1ns/10ps
`include "dmahs_defines.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
   $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module dmahs_top_tb;
   typedef struct packed {logic [1:0] m; logic d; logic [2:0] w; logic e; logic [3:0] h;
      logic g;} dmahs_row_t;
   dmahs_row_t rows [0:6] = '{'{2'h0, 1'h1, 3'h0, 1'h0, 4'h6, 1'h1},
      '{2'h0, 1'h0, 3'h2, 1'h0, 4'h5, 1'h1}, '{2'h1, 1'h1, 3'h1, 1'h1, 4'h0, 1'h1},
      '{2'h1, 1'h0, 3'h0, 1'h0, 4'h0, 1'h1}, '{2'h2, 1'h1, 3'h0, 1'h0, 4'h0, 1'h0},
      '{2'h2, 1'h0, 3'h3, 1'h0, 4'h2, 1'h0}, '{2'h3, 1'h0, 3'h7, 1'h1, 4'h0, 1'h1}};
   reg         clk_sys = 1'b0, rst_b = 1'b0, dir_write = 1'b0, idle_en = 1'b0;
   reg         tx_valid = 1'b0, rx_ready = 1'b1, go = 1'b0;
   reg  [1:0]  mode = 2'h0;
   reg  [2:0]  wait_states = 3'h0;
   reg  [3:0]  hold = 4'h0;
   reg  [31:0] tx_data = 32'h0, word = 32'h0, dseen, got;
   reg  [15:0] c0;
   reg  [23:0] aseen;
   reg  [3:0]  mseen;
   wire        req_n, grant_n, rd_n, wr_n, ack, tx_ready, rx_valid, data_oe, busy;
   wire [31:0] data_in, data_out, rx_data;
   wire [23:0] addr;
   wire [3:0]  msel_n;
   wire [15:0] xcount;
   int         errors = 0, checks = 0, gl, sl, lat, a, i, tr;
   logic [31:0] q [$];
   always #5 clk_sys = ~clk_sys;
   dmahs_top dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .MODE(mode), .DIR_WRITE(dir_write),
      .WAIT_STATES(wait_states), .IDLE_EN(idle_en), .START_ADDR(24'h000100),
      .MEM_SEL(4'h1), .DMA_REQ_N(req_n), .DMA_GRANT_N(grant_n), .EXT_ADDR_BUS(addr),
      .RD_N(rd_n), .WR_N(wr_n), .MEM_SELECT_N(msel_n), .ACK(ack), .DATA_IN(data_in),
      .DATA_OUT(data_out), .DATA_OE(data_oe), .TX_VALID(tx_valid), .TX_READY(tx_ready),
      .TX_DATA(tx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data),
      .BUSY(busy), .XFER_COUNT(xcount));
   dmahs_party party_u (.clk(clk_sys), .rst_b(rst_b), .go(go), .hold(hold), .word(word),
      .grant_n(grant_n), .rd_n(rd_n), .wr_n(wr_n), .req_n(req_n), .ack(ack),
      .data_in(data_in));
   task stop_test;
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // ==========================================
   // one request, watched until the port has been idle for six cycles
   task run;
      int n, k;
      begin
         n = 0; k = 0; gl = 0; sl = 0; lat = 0; dseen = ~word; c0 = xcount;
         tr = 0;
         aseen = 24'h000000;
         mseen = 4'h0;
         tx_data <= word;
         tx_valid <= dir_write;
         go <= 1'b1;
         @(posedge clk_sys) go <= 1'b0;
         while (k < 6 && n < 300) begin
            if (sl > 0 && busy === 1'b0 && (rd_n & wr_n & grant_n) === 1'b1) k++;
            else k = 0;
            if (grant_n === 1'b0) gl++;
            if ((rd_n & wr_n) === 1'b0) begin
               sl++;
               aseen = addr;
               mseen = msel_n;
            end else if (sl == 0) begin
               lat++;
            end
            if (data_oe === 1'b1 && (rd_n & wr_n) === 1'b0) dseen = data_out;
            if (tx_ready === 1'b1) begin
               tx_valid <= 1'b0;
               tr++;
            end
            if (rx_valid === 1'b1 && rx_ready) q.push_back(rx_data);
            @(posedge clk_sys) n++;
         end
         `CHK("done", 1'b1, n < 300)
      end
   endtask
   initial begin
      #100000;
      errors++;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (i = 0; i < 7; i++) begin
         mode <= rows[i].m;
         dir_write <= rows[i].d;
         wait_states <= rows[i].w;
         idle_en <= rows[i].e;
         hold <= rows[i].h;
         word <= 32'ha5c30000 | i;
         @(posedge clk_sys);
         run;
         got = rows[i].d ? dseen : q.pop_front();
         `CHK("grant", rows[i].g, gl > 0)
         `CHK("strobe", 1'b1, sl > 0)
         `CHK("width", rows[i].g, gl >= 4 + 2 * rows[i].w)
         `CHK("held", 1'b1, sl > rows[i].h)
         `CHK("count", c0 + 16'h1, xcount)
         `CHK("data", word, got)
         `CHK("ack", 1'b1, rows[i].m == 2'h0 || sl > 6)
         `CHK("select", rows[i].m == 2'h0 ? 4'hf : 4'he, mseen)
         if (rows[i].m != 2'h0) `CHK("addr", i + 24'h0000fe, aseen)
         `CHK("taken", rows[i].d, tr == 1)
         $display("row %0d done", i);
      end
      mode <= `DMAHS_MODE_HS;
      // the idle cycle is armed by the transfer before, so two runs per setting
      for (i = 0; i < 4; i++) begin
         idle_en <= (i > 1);
         @(posedge clk_sys);
         run;
         if (i == 1) a = lat;
      end
      `CHK("idle", 1'b1, lat > a)
      q.delete();
      $display("idle test done");
      rx_ready <= 1'b0;
      for (i = 1; i < 4; i++) begin
         word <= 32'h5a5a0000 | i;
         @(posedge clk_sys);
         run;
      end
      c0 = xcount;
      go <= 1'b1;
      @(posedge clk_sys) go <= 1'b0;
      repeat (40) @(posedge clk_sys);
      `CHK("full", c0, xcount)
      rx_ready <= 1'b1;
      repeat (8) @(posedge clk_sys) if (rx_valid === 1'b1 && rx_ready) q.push_back(rx_data);
      `CHK("order", {32'h5a5a0001, 32'h5a5a0002, 32'h5a5a0003}, {q[0], q[1], q[2]})
      rst_b <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK("reset", {3'h7, 4'hf, 17'h0}, {grant_n, rd_n, wr_n, msel_n, data_oe, xcount})
      $display("buffer and reset test done");
      stop_test;
   end
endmodule // dmahs_top_tb
